// *** tb/bltu_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Stands in for the pipeline stages that program the unit over the register bus.
// A released address or data line shows the inverse of its last value, so that a
// slave which samples late reads junk instead of a value that only looks right.
module bltu_host (
	input  wire logic        clk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		forever begin
			@(posedge clk);
			if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
			if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~d};
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		forever begin
			@(posedge clk);
			if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
			if (rvalid) begin
				{d, r} = {rdata, rresp};
				rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [31:0] res[5];
	logic [1:0]  bresp, rresp, rr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          n_mismatch = 0;
	int          compares = 0;
	always #2 clk = ~clk;
	bltu_host host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	bltu_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		host.wr(a, d, rr);
		chk(rr, 2'h0);
	endtask
	// Results need two cycles after the control write; status and results are contiguous.
	task automatic op(input logic [31:0] c);
		w(bltu_pkg::OFS_CTRL, c);
		repeat (3) @(posedge clk);
		for (int i = 0; i < 5; i++) host.rd(bltu_pkg::OFS_STATUS + 8'(4 * i), res[i], rr);
		chk(res[0][bltu_pkg::ST_DONE], 1'b1);
	endtask
	function automatic logic ce(input logic [3:0] c, input logic [31:0] f);
		logic [7:0] r;
		r = {f[7] ^ f[11] | f[6], f[7] ^ f[11], f[2], f[7], f[0] | f[6], f[6], f[0], f[11]};
		return r[c[3:1]] ^ c[0];
	endfunction
	task automatic lp(input logic [31:0] c, lo, hi, tk, el, eh);
		w(bltu_pkg::OFS_CNT_LO, lo);
		w(bltu_pkg::OFS_CNT_HI, hi);
		op(c);
		chk(res[0][1], tk);
		chk(res[3], el);
		chk(res[4], eh);
	endtask
	task automatic tp(input logic [31:0] c, ex, vec, inv);
		op(c);
		chk(res[0][2], ex);
		chk(res[0][3], inv);
		if (ex) chk(res[0][15:8], vec);
	endtask
	task automatic t_bus;
		logic [31:0] d;
		host.rd(bltu_pkg::OFS_DISP, d, rr);
		chk(d, bltu_pkg::RST_WORD);
		chk(rr, 2'h0);
		host.rd(8'h30, d, rr);
		chk(rr, 2'h2);
		host.wr(bltu_pkg::OFS_STATUS, 32'h1, rr);
		chk(rr, 2'h2);
		$display("test bus done");
	endtask
	task automatic t_cond;
		logic [31:0] f[4] = '{32'h0, 32'h845, 32'h80, 32'h41};
		w(bltu_pkg::OFS_IP_LO, 32'hffff_fff0);
		w(bltu_pkg::OFS_DISP, 32'h20);
		foreach (f[i]) for (int c = 0; c < 16; c++) begin
			w(bltu_pkg::OFS_FLAGS, f[i]);
			w(bltu_pkg::OFS_COND, 32'(c));
			op(32'h0);
			chk(res[0][1], ce(4'(c), f[i]));
			chk(res[1], ce(4'(c), f[i]) ? 32'h10 : 32'hffff_fff0);
			chk(res[2], 32'h0);
		end
		w(bltu_pkg::OFS_FLAGS, 32'h40);
		w(bltu_pkg::OFS_COND, 32'h4);
		w(bltu_pkg::OFS_IP_HI, 32'h1);
		w(bltu_pkg::OFS_IP_LO, 32'h10);
		w(bltu_pkg::OFS_DISP, 32'hffff_ff00);
		op(32'h50);
		chk(res[1], 32'hffff_ff10);
		chk(res[2], 32'h0);
		w(bltu_pkg::OFS_DISP, 32'h20);
		op(32'h50);
		chk(res[1], 32'h30);
		chk(res[2], 32'h1);
		w(bltu_pkg::OFS_IP_LO, 32'h1_fff0);
		op(32'h100);
		chk(res[1], 32'h10);
		chk(res[2], 32'h0);
		$display("test cond done");
	endtask
	task automatic t_loop;
		lp(32'h1, 32'h0, 32'h5, 1, 32'hffff_ffff, 32'h5);
		lp(32'h1, 32'h1, 32'h5, 0, 32'h0, 32'h5);
		lp(32'h11, 0, 0, 1, 32'hffff_ffff, 32'hffff_ffff);
		lp(32'h51, 0, 0, 1, 32'hffff_ffff, 0);
		lp(32'h81, 32'h1_0000, 0, 1, 32'h1_ffff, 0);
		lp(32'h84, 32'h1_0000, 0, 1, 32'h1_0000, 0);
		lp(32'h4, 32'h1_0000, 0, 0, 32'h1_0000, 0);
		lp(32'h4, 0, 32'h7, 1, 0, 32'h7);
		lp(32'h14, 0, 32'h1, 0, 0, 32'h1);
		for (int k = 0; k < 4; k++) begin
			w(bltu_pkg::OFS_FLAGS, k[0] ? 32'h40 : 32'h0);
			lp(32'h2, 32'(k[1]) + 1, 0, k[0] & k[1], 32'(k[1]), 0);
			lp(32'h3, 32'(k[1]) + 1, 0, !k[0] & k[1], 32'(k[1]), 0);
		end
		$display("test loop done");
	endtask
	task automatic t_trap;
		logic signed [31:0] v[4] = '{-6, -5, 10, 11};
		w(bltu_pkg::OFS_FLAGS, 32'h800);
		tp(32'h6, 1, 8'h04, 0);
		w(bltu_pkg::OFS_FLAGS, 32'h0);
		tp(32'h6, 0, 0, 0);
		tp(32'h00a5_0005, 1, 8'ha5, 0);
		chk(res[0][21], 1'b1);
		w(bltu_pkg::OFS_BLOW, -5);
		w(bltu_pkg::OFS_BUP, 10);
		foreach (v[i]) begin
			w(bltu_pkg::OFS_BVAL, v[i]);
			tp(32'h7, v[i] < -5 || v[i] > 10, 8'h05, 0);
		end
		tp(32'h17, 0, 0, 1);
		tp(32'hf, 0, 0, 1);
		$display("test trap done");
	endtask
	task automatic t_ret;
		op(32'h18);
		chk(res[0][22:16], 7'h58);
		op(32'h28);
		chk(res[0][20], 1'b0);
		op(32'h228);
		chk(res[0][20], 1'b1);
		op(32'h119);
		chk(res[0][19:16], 4'h8);
		op(32'h10a);
		chk(res[0][19:16], 4'h2);
		$display("test resume done");
	endtask
	task automatic give_verdict;
		$display("compares %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_bus();
		t_cond();
		t_loop();
		t_trap();
		t_ret();
		give_verdict();
	end
	initial begin
		#200000;
		n_mismatch++;
		give_verdict();
	end
endmodule
`default_nettype wire

// *** verilog/bltu_cond.sv ***
`timescale 1ns/1ps
`default_nettype none
module bltu_cond (
	bltu_eval_if.cond ev
);
	wire carry_flag    = ev.flags[bltu_pkg::FLG_CARRY];
	wire parity_flag   = ev.flags[bltu_pkg::FLG_PARITY];
	wire zero_flag     = ev.flags[bltu_pkg::FLG_ZERO];
	wire sign_flag     = ev.flags[bltu_pkg::FLG_SIGN];
	wire overflow_flag = ev.flags[bltu_pkg::FLG_OVERFLOW];
	// Even codes test the base condition, odd codes its inverse.
	wire [7:0] base = {(sign_flag ^ overflow_flag) | zero_flag, sign_flag ^ overflow_flag,
		parity_flag, sign_flag, carry_flag | zero_flag, zero_flag, carry_flag,
		overflow_flag};
	assign ev.cond_true = base[ev.cc[3:1]] ^ ev.cc[0];
endmodule
`default_nettype wire

// *** verilog/bltu_eval_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface bltu_eval_if;
	logic [31:0] flags;
	logic [3:0]  cc;
	logic        cond_true;
	logic [63:0] next_ip;
	logic [31:0] disp;
	logic [1:0]  ipw;
	logic [63:0] cnt;
	logic [1:0]  asz;
	logic [63:0] target;
	logic [63:0] cnt_dec;
	logic        dec_nz;
	logic        cnt_z;
	modport cond (input flags, cc, output cond_true);
	modport tgt  (input next_ip, disp, ipw, cnt, asz, output target, cnt_dec, dec_nz, cnt_z);
	modport core (output flags, cc, next_ip, disp, ipw, cnt, asz,
		input cond_true, target, cnt_dec, dec_nz, cnt_z);
endinterface
`default_nettype wire

// *** verilog/bltu_pkg.sv ***
`default_nettype none
package bltu_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_FLAGS   = 8'h04;
	localparam logic [7:0] OFS_COND    = 8'h08;
	localparam logic [7:0] OFS_IP_LO   = 8'h0c;
	localparam logic [7:0] OFS_IP_HI   = 8'h10;
	localparam logic [7:0] OFS_DISP    = 8'h14;
	localparam logic [7:0] OFS_CNT_LO  = 8'h18;
	localparam logic [7:0] OFS_CNT_HI  = 8'h1c;
	localparam logic [7:0] OFS_BVAL    = 8'h20;
	localparam logic [7:0] OFS_BLOW    = 8'h24;
	localparam logic [7:0] OFS_BUP     = 8'h28;
	localparam logic [7:0] OFS_STATUS  = 8'h34;
	localparam logic [7:0] OFS_TGT_LO  = 8'h38;
	localparam logic [7:0] OFS_TGT_HI  = 8'h3c;
	localparam logic [7:0] OFS_NCNT_LO = 8'h40;
	localparam logic [7:0] OFS_NCNT_HI = 8'h44;
	// Control register fields.
	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_MODE64   = 4;
	localparam int CTRL_COMPAT   = 5;
	localparam int CTRL_ASZ_PFX  = 6;
	localparam int CTRL_ASZ16    = 7;
	localparam int CTRL_OSZ16    = 8;
	localparam int CTRL_PRIV_CHG = 9;
	localparam int CTRL_VEC_LSB  = 16;
	// Flag positions inside flags_ff.
	localparam int FLG_CARRY    = 0;
	localparam int FLG_PARITY   = 2;
	localparam int FLG_ZERO     = 6;
	localparam int FLG_SIGN     = 7;
	localparam int FLG_OVERFLOW = 11;
	// Status register fields.
	localparam int ST_DONE   = 0;
	localparam int ST_TAKEN  = 1;
	localparam int ST_EXC    = 2;
	localparam int ST_INVAL  = 3;
	localparam int ST_VEC    = 8;
	localparam int ST_SBYTES = 16;
	localparam int ST_POPSP  = 20;
	localparam int ST_PUSHF  = 21;
	localparam int ST_RELF   = 22;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Operations.
	localparam logic [3:0] OP_COND   = 4'h0;
	localparam logic [3:0] OP_LOOP   = 4'h1;
	localparam logic [3:0] OP_LOOPE  = 4'h2;
	localparam logic [3:0] OP_LOOPNE = 4'h3;
	localparam logic [3:0] OP_JCZ    = 4'h4;
	localparam logic [3:0] OP_INTN   = 4'h5;
	localparam logic [3:0] OP_INTO   = 4'h6;
	localparam logic [3:0] OP_BOUND  = 4'h7;
	localparam logic [3:0] OP_RESUME = 4'h8;
	localparam logic [3:0] OP_CALL   = 4'h9;
	localparam logic [3:0] OP_BACK   = 4'ha;
	// Width codes for address size and instruction pointer size.
	localparam logic [1:0] W16 = 2'h0;
	localparam logic [1:0] W32 = 2'h1;
	localparam logic [1:0] W64 = 2'h2;
	localparam logic [3:0] SBYTES_64 = 4'h8;
	localparam logic [3:0] SBYTES_32 = 4'h4;
	localparam logic [3:0] SBYTES_16 = 4'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EVAL = 2'b10
	} bltu_state_e;
endpackage
`default_nettype wire

// *** verilog/bltu_target.sv ***
`timescale 1ns/1ps
`default_nettype none
module bltu_target (
	bltu_eval_if.tgt ev
);
	// Only near relative targets are formed; no segment is ever changed.
	wire [63:0] sum = ev.next_ip + {{32{ev.disp[31]}}, ev.disp};
	assign ev.target = (ev.ipw == bltu_pkg::W16) ? {48'h0, sum[15:0]} :
		(ev.ipw == bltu_pkg::W32) ? {32'h0, sum[31:0]} : sum;
	// A zero count wraps to all ones, so the loop runs the full range.
	wire [63:0] dec = ev.cnt - 64'h1;
	// A narrow count leaves the bits above its width untouched.
	assign ev.cnt_dec = (ev.asz == bltu_pkg::W16) ? {ev.cnt[63:16], dec[15:0]} :
		(ev.asz == bltu_pkg::W32) ? {ev.cnt[63:32], dec[31:0]} : dec;
	assign ev.dec_nz = (ev.asz == bltu_pkg::W16) ? (dec[15:0] != 16'h0) :
		(ev.asz == bltu_pkg::W32) ? (dec[31:0] != 32'h0) : (dec != 64'h0);
	assign ev.cnt_z = (ev.asz == bltu_pkg::W16) ? (ev.cnt[15:0] == 16'h0) :
		(ev.asz == bltu_pkg::W32) ? (ev.cnt[31:0] == 32'h0) : (ev.cnt == 64'h0);
endmodule
`default_nettype wire

// *** verilog/bltu_top.sv ***
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bltu_top #(
	parameter logic [7:0] VEC_OVERFLOW = 8'h04,
	parameter logic [7:0] VEC_RANGE    = 8'h05,
	parameter int         ADDR_W       = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	if (ADDR_W < 8) begin : g_addr_check
		$error("ADDR_W too small for the register map");
	end

	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i])
				r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic writable(input logic [7:0] a);
		return a == bltu_pkg::OFS_CTRL || a == bltu_pkg::OFS_FLAGS || a == bltu_pkg::OFS_COND ||
			a == bltu_pkg::OFS_IP_LO || a == bltu_pkg::OFS_IP_HI || a == bltu_pkg::OFS_DISP ||
			a == bltu_pkg::OFS_CNT_LO || a == bltu_pkg::OFS_CNT_HI || a == bltu_pkg::OFS_BVAL ||
			a == bltu_pkg::OFS_BLOW || a == bltu_pkg::OFS_BUP;
	endfunction

	function automatic logic readonly(input logic [7:0] a);
		return a == bltu_pkg::OFS_STATUS || a == bltu_pkg::OFS_TGT_LO ||
			a == bltu_pkg::OFS_TGT_HI || a == bltu_pkg::OFS_NCNT_LO ||
			a == bltu_pkg::OFS_NCNT_HI;
	endfunction

	// Write channel capture; address and data may arrive in either order.
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [7:0]  aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;

	wire       aw_fire = s_axi_awvalid & s_axi_awready;
	wire       w_fire  = s_axi_wvalid & s_axi_wready;
	wire       ar_fire = s_axi_arvalid & s_axi_arready;
	wire       wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire [7:0] ar_addr = s_axi_araddr[7:0];
	wire       wr_ok   = writable(aw_addr_ff) && aw_addr_ff[1:0] == 2'h0;
	wire       rd_ok   = (writable(ar_addr) || readonly(ar_addr)) && ar_addr[1:0] == 2'h0;

	assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= bltu_pkg::RST_WORD;
			w_strb_ff  <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OK;
		end else begin
			if (aw_fire) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr[7:0];
			end
			if (w_fire) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_ok ? RESP_OK : RESP_ERR;
			end else if (s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// Software-written operand registers.
	logic [31:0] ctrl_ff;
	logic [31:0] flags_ff;
	logic [31:0] cc_ff;
	logic [63:0] ip_ff;
	logic [31:0] disp_ff;
	logic [63:0] cnt_ff;
	logic [31:0] bval_ff;
	logic [31:0] blow_ff;
	logic [31:0] bup_ff;

	wire wr_en = wr_fire & wr_ok;
	wire [31:0] cc_merge = strb_merge(cc_ff, w_data_ff, w_strb_ff);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff  <= bltu_pkg::RST_WORD;
			flags_ff <= bltu_pkg::RST_WORD;
			cc_ff    <= bltu_pkg::RST_WORD;
			ip_ff    <= {2{bltu_pkg::RST_WORD}};
			disp_ff  <= bltu_pkg::RST_WORD;
			cnt_ff   <= {2{bltu_pkg::RST_WORD}};
			bval_ff  <= bltu_pkg::RST_WORD;
			blow_ff  <= bltu_pkg::RST_WORD;
			bup_ff   <= bltu_pkg::RST_WORD;
		end else if (wr_en) begin
			if (hit(aw_addr_ff, bltu_pkg::OFS_CTRL))
				ctrl_ff <= strb_merge(ctrl_ff, w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_FLAGS))
				flags_ff <= strb_merge(flags_ff, w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_COND))
				cc_ff <= {28'h0, cc_merge[3:0]};
			if (hit(aw_addr_ff, bltu_pkg::OFS_IP_LO))
				ip_ff[31:0] <= strb_merge(ip_ff[31:0], w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_IP_HI))
				ip_ff[63:32] <= strb_merge(ip_ff[63:32], w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_DISP))
				disp_ff <= strb_merge(disp_ff, w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_CNT_LO))
				cnt_ff[31:0] <= strb_merge(cnt_ff[31:0], w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_CNT_HI))
				cnt_ff[63:32] <= strb_merge(cnt_ff[63:32], w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_BVAL))
				bval_ff <= strb_merge(bval_ff, w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_BLOW))
				blow_ff <= strb_merge(blow_ff, w_data_ff, w_strb_ff);
			if (hit(aw_addr_ff, bltu_pkg::OFS_BUP))
				bup_ff <= strb_merge(bup_ff, w_data_ff, w_strb_ff);
		end
	end

	// Decoded control fields.
	wire [3:0] op     = ctrl_ff[bltu_pkg::CTRL_OP_LSB +: 4];
	wire       mode64 = ctrl_ff[bltu_pkg::CTRL_MODE64];
	wire       osz16  = ctrl_ff[bltu_pkg::CTRL_OSZ16];
	wire       priv_chg = ctrl_ff[bltu_pkg::CTRL_PRIV_CHG];
	wire [7:0] vec    = ctrl_ff[bltu_pkg::CTRL_VEC_LSB +: 8];
	wire       zero_flag = flags_ff[bltu_pkg::FLG_ZERO];
	wire       overflow_flag = flags_ff[bltu_pkg::FLG_OVERFLOW];

	bltu_eval_if ev ();
	bltu_cond   u_cond (.ev(ev));
	bltu_target u_tgt  (.ev(ev));

	assign ev.flags   = flags_ff;
	assign ev.cc      = cc_ff[3:0];
	assign ev.next_ip = ip_ff;
	assign ev.disp    = disp_ff;
	assign ev.cnt     = cnt_ff;
	// Operand-size prefixes are ignored for the pointer in 64-bit mode.
	assign ev.ipw = mode64 ? bltu_pkg::W64 : (osz16 ? bltu_pkg::W16 : bltu_pkg::W32);
	// The 64-bit default can only be narrowed to 32 by the prefix.
	assign ev.asz = mode64 ? (ctrl_ff[bltu_pkg::CTRL_ASZ_PFX] ? bltu_pkg::W32 : bltu_pkg::W64) :
		(ctrl_ff[bltu_pkg::CTRL_ASZ16] ? bltu_pkg::W16 : bltu_pkg::W32);

	wire is_loop  = op == bltu_pkg::OP_LOOP || op == bltu_pkg::OP_LOOPE ||
		op == bltu_pkg::OP_LOOPNE;
	wire out_of_range = $signed(bval_ff) < $signed(blow_ff) ||
		$signed(bval_ff) > $signed(bup_ff);
	wire known_op = op <= bltu_pkg::OP_BACK;

	wire taken_c = (op == bltu_pkg::OP_COND) ? ev.cond_true :
		(op == bltu_pkg::OP_LOOP) ? ev.dec_nz :
		(op == bltu_pkg::OP_LOOPE) ? (ev.dec_nz & zero_flag) :
		(op == bltu_pkg::OP_LOOPNE) ? (ev.dec_nz & ~zero_flag) :
		(op == bltu_pkg::OP_JCZ) ? ev.cnt_z : 1'b0;
	wire inval_c = ~known_op | (op == bltu_pkg::OP_BOUND & mode64);
	wire exc_c = (op == bltu_pkg::OP_INTN) |
		(op == bltu_pkg::OP_INTO & overflow_flag) |
		(op == bltu_pkg::OP_BOUND & ~mode64 & out_of_range);
	wire [7:0] vec_c = (op == bltu_pkg::OP_INTO) ? VEC_OVERFLOW :
		(op == bltu_pkg::OP_BOUND) ? VEC_RANGE : vec;
	wire [3:0] sbytes_c = mode64 ? bltu_pkg::SBYTES_64 :
		(osz16 ? bltu_pkg::SBYTES_16 : bltu_pkg::SBYTES_32);
	// Outside 64-bit mode, compatibility and legacy alike, the stack pointer is only
	// popped on a privilege change.
	wire popsp_c = op == bltu_pkg::OP_RESUME & (mode64 | priv_chg);
	wire [63:0] tgt_c  = taken_c ? ev.target : ip_ff;
	wire [63:0] ncnt_c = is_loop ? ev.cnt_dec : cnt_ff;

	// Evaluation sequencer and result registers.
	bltu_pkg::bltu_state_e state_ff;
	bltu_pkg::bltu_state_e nxt_state;
	wire start = wr_en & hit(aw_addr_ff, bltu_pkg::OFS_CTRL);
	always_comb begin
		case (state_ff)
			bltu_pkg::ST_IDLE: nxt_state = start ? bltu_pkg::ST_EVAL : bltu_pkg::ST_IDLE;
			bltu_pkg::ST_EVAL: nxt_state = bltu_pkg::ST_IDLE;
			default:           nxt_state = bltu_pkg::ST_IDLE;
		endcase
	end
	wire eval = state_ff == bltu_pkg::ST_EVAL;

	logic        done_ff;
	logic        taken_ff;
	logic        exc_ff;
	logic        inval_ff;
	logic [7:0]  vec_ff;
	logic [3:0]  sbytes_ff;
	logic        popsp_ff;
	logic        pushf_ff;
	logic        relf_ff;
	logic [63:0] tgt_ff;
	logic [63:0] ncnt_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_ff <= bltu_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_ff   <= 1'b0;
			taken_ff  <= 1'b0;
			exc_ff    <= 1'b0;
			inval_ff  <= 1'b0;
			vec_ff    <= 8'h00;
			sbytes_ff <= 4'h0;
			popsp_ff  <= 1'b0;
			pushf_ff  <= 1'b0;
			relf_ff   <= 1'b0;
			tgt_ff    <= 64'h0;
			ncnt_ff   <= 64'h0;
		end else if (eval) begin
			// Completion wins over a clear from a new start in the same cycle.
			done_ff   <= 1'b1;
			taken_ff  <= taken_c;
			exc_ff    <= exc_c & ~inval_c;
			inval_ff  <= inval_c;
			vec_ff    <= vec_c;
			sbytes_ff <= sbytes_c;
			popsp_ff  <= popsp_c;
			pushf_ff  <= exc_c & ~inval_c;
			relf_ff   <= op == bltu_pkg::OP_RESUME;
			tgt_ff    <= tgt_c;
			ncnt_ff   <= ncnt_c;
		end else if (start)
			done_ff <= 1'b0;
	end

	wire [31:0] status = {9'h0, relf_ff, pushf_ff, popsp_ff, sbytes_ff, vec_ff,
		4'h0, inval_ff, exc_ff, taken_ff, done_ff};

	wire [31:0] rd_mux =
		(ar_addr == bltu_pkg::OFS_CTRL)    ? ctrl_ff :
		(ar_addr == bltu_pkg::OFS_FLAGS)   ? flags_ff :
		(ar_addr == bltu_pkg::OFS_COND)    ? cc_ff :
		(ar_addr == bltu_pkg::OFS_IP_LO)   ? ip_ff[31:0] :
		(ar_addr == bltu_pkg::OFS_IP_HI)   ? ip_ff[63:32] :
		(ar_addr == bltu_pkg::OFS_DISP)    ? disp_ff :
		(ar_addr == bltu_pkg::OFS_CNT_LO)  ? cnt_ff[31:0] :
		(ar_addr == bltu_pkg::OFS_CNT_HI)  ? cnt_ff[63:32] :
		(ar_addr == bltu_pkg::OFS_BVAL)    ? bval_ff :
		(ar_addr == bltu_pkg::OFS_BLOW)    ? blow_ff :
		(ar_addr == bltu_pkg::OFS_BUP)     ? bup_ff :
		(ar_addr == bltu_pkg::OFS_STATUS)  ? status :
		(ar_addr == bltu_pkg::OFS_TGT_LO)  ? tgt_ff[31:0] :
		(ar_addr == bltu_pkg::OFS_TGT_HI)  ? tgt_ff[63:32] :
		(ar_addr == bltu_pkg::OFS_NCNT_LO) ? ncnt_ff[31:0] :
		(ar_addr == bltu_pkg::OFS_NCNT_HI) ? ncnt_ff[63:32] : bltu_pkg::RST_WORD;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= RESP_OK;
			rdata_ff  <= bltu_pkg::RST_WORD;
		end else if (ar_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= rd_ok ? RESP_OK : RESP_ERR;
			rdata_ff  <= rd_ok ? rd_mux : bltu_pkg::RST_WORD;
		end else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// Checks on the evaluation results and the bus.
	chk_write_resp: assert property (@(posedge clk) disable iff (rst)
		$rose(bvalid_ff) |-> $past(aw_held_ff & w_held_ff))
		else $error("write response without address and data");
	chk_eval_done: assert property (@(posedge clk) disable iff (rst)
		start |=> eval ##1 done_ff)
		else $error("evaluation did not complete in two cycles");
	chk_loop_wrap: assert property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_LOOP && ev.asz == bltu_pkg::W64 && cnt_ff == 64'h0
		|=> ncnt_ff == 64'hffff_ffff_ffff_ffff && taken_ff)
		else $error("zero count did not wrap to all ones");
	chk_equal_loop: assert property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_LOOPE && !zero_flag |=> !taken_ff && tgt_ff == $past(ip_ff))
		else $error("while-equal loop taken with zero flag clear");
	chk_unequal_loop: assert property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_LOOPNE && zero_flag |=> !taken_ff)
		else $error("while-unequal loop taken with zero flag set");
	chk_jcz_keep: assert property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_JCZ |=> ncnt_ff == $past(cnt_ff) && taken_ff ==
		($past(ev.asz) == bltu_pkg::W16 ? $past(cnt_ff[15:0]) == 16'h0 :
		$past(ev.asz) == bltu_pkg::W32 ? $past(cnt_ff[31:0]) == 32'h0 : $past(cnt_ff) == 64'h0))
		else $error("count-zero branch altered count or misjudged");
	chk_into_clear: assert property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_INTO |=> exc_ff == $past(overflow_flag))
		else $error("overflow trap disagrees with overflow flag");
	chk_bound_64: assert property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_BOUND && mode64 |=> inval_ff && !exc_ff)
		else $error("range check accepted in 64-bit mode");
	chk_stack_64: assert property (@(posedge clk) disable iff (rst)
		eval && mode64 |=> sbytes_ff == bltu_pkg::SBYTES_64)
		else $error("stack item not 8 bytes in 64-bit mode");
	chk_resume_pop: assert property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_RESUME && !mode64 |=> popsp_ff == $past(priv_chg) && relf_ff)
		else $error("resume stack pop wrong outside 64-bit mode");
	chk_tgt_trunc: assert property (@(posedge clk) disable iff (rst)
		eval && !mode64 && osz16 && taken_c |=> tgt_ff[63:16] == 48'h0)
		else $error("16-bit target not truncated");

	cov_loop_taken: cover property (@(posedge clk) disable iff (rst)
		eval && is_loop ##1 taken_ff);
	cov_trap_raise: cover property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_BOUND ##1 exc_ff);
	cov_resume_64: cover property (@(posedge clk) disable iff (rst)
		eval && op == bltu_pkg::OP_RESUME && mode64 ##1 popsp_ff);
	cov_read_back: cover property (@(posedge clk) disable iff (rst)
		ar_fire ##1 rvalid_ff && s_axi_rready);
endmodule
`default_nettype wire
